// ==== rtl/tcd_consts.svh ====
// Offsets, field positions, reset values and timing counts of the tuner control decoder
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH
`define TCD_OFF_WORD0 8'h00
`define TCD_OFF_WORD1 8'h04
`define TCD_OFF_WORD2 8'h08
`define TCD_OFF_WORD3 8'h0C
`define TCD_OFF_WORD4 8'h10
`define TCD_OFF_COMMIT 8'h14
`define TCD_OFF_STATUS 8'h18
`define TCD_NWORDS 5
`define TCD_RST_WORD 32'h00000000
`define TCD_B_PLL_ON 4
`define TCD_B_DIV_SEL 5
`define TCD_B_IFG_LO 6
`define TCD_B_IFG_HI 9
`define TCD_B_OSC_LOW 10
`define TCD_B_IF_IN_AM 11
`define TCD_B_RF_LO 12
`define TCD_B_RF_HI 15
`define TCD_B_AM_MODE 17
`define TCD_B_DEL_SEL 18
`define TCD_B_DEL1_LO 20
`define TCD_B_DEL2_LO 22
`define TCD_B_NO_SHIFT 32
`define TCD_B_SW1_LOW 46
`define TCD_B_SW2_LOW 47
`define TCD_B_SW2_SWITCH 48
`define TCD_B_WIRE_SUP 60
`define TCD_B_IMP_SUP 61
`define TCD_B_HC_2MA 62
`define TCD_B_LC_DOUBLE 63
`define TCD_B_TEST 123
`define TCD_B_PRE_LO 140
`define TCD_B_PRE_TEN 143
`define TCD_B_FRAC_OFF 144
`define TCD_B_PD_AM 145
`define TCD_IFG_BASE_DB 6'h0C
`define TCD_RF_AM_BASE_DB 7'h58
`define TCD_RF_FM_BASE_DB 7'h5B
`define TCD_PRE_BASE 4'h2
`define TCD_PRE_TEN_DIV 4'hA
`define TCD_CLK_PERIOD_NS 5
`define TCD_DELAY_STEP_NS 5
`define TCD_DELAY_CYC(c) (((c) * `TCD_DELAY_STEP_NS + `TCD_CLK_PERIOD_NS - 1) / `TCD_CLK_PERIOD_NS)
`endif

// ==== rtl/tcd_ctrl_top.sv ====
// Tuner control word bank: register port, load commit and decode of all settings
`timescale 1ns/100ps
`include "tcd_consts.svh"
// Notes on behaviour
// - IF gain 12 dB plus 2 dB per code
// - Bit 11 picks AM or FM IF input
// - Bit 10 set means low oscillator current
// - RF threshold 1 dB steps, AM/FM base
// - Bit 17 enables AM or FM blocks
// - Bit 4 powers PLL, else divider grounded
// - Bit 18 picks which delay field applies
// - Delay codes: off, 5, 10, 15 ns
// - Shift dividers during change unless bit 32
// - Bit 46 set pulls switch one low
// - Bit 48 picks gain pin or switch
// - AM prescaler divides 2 to 10
// - Fraction off with shift zeroes low bits
// - Spur suppressors only in fractional shift mode
// - High pump during change, skipped if zero
// - Bit 62 picks 1 or 2 mA
// - Bit 63 doubles low pump current
// - Bit 5 picks active main divider
module tcd_ctrl_top
    import tcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_ff,
    input wire logic lock_detect_pin,
    output logic [5:0] if_gain_db_ff,
    output logic if_in_am_ff,
    output logic osc_low_current_ff,
    output logic [6:0] rf_gain_threshold_ff,
    output logic am_mixer_en_ff,
    output logic am_rf_gain_threshold_en_ff,
    output logic am_prescaler_en_ff,
    output logic am_if_amp_en_ff,
    output logic fm_mixer_en_ff,
    output logic fm_rf_gain_threshold_en_ff,
    output logic fm_if_amp_en_ff,
    output logic am_phase_detector_path_ff,
    output logic fm_phase_detector_path_ff,
    output logic pll_power_ff,
    output logic div_input_grounded_ff,
    output logic main_divider_select_ff,
    output logic [1:0] pump_delay_select_ff,
    output logic divider_shift_ff,
    output logic frac_mode_ff,
    output logic n_low_bits_zero_ff,
    output logic wire_spur_suppress_ff,
    output logic impulse_spur_suppress_ff,
    output logic hc_pump_active_ff,
    output logic lc_pump_active_ff,
    output logic hc_pump_2ma_ff,
    output logic lc_pump_double_ff,
    output logic switch_output_one_o_ff,
    output logic switch_output_one_oe_ff,
    output logic switch_two_or_gain_pin_o_ff,
    output logic switch_two_or_gain_pin_oe_ff,
    output logic gain_pin_agc_mode_ff,
    output logic [3:0] am_prescale_div_ff,
    output logic test_mode_ff
);
    logic [31:0] shadow_ff [`TCD_NWORDS];
    logic [32*`TCD_NWORDS-1:0] act_ff;
    logic commit_ff;
    logic lk_s1_ff;
    logic lk_s2_ff;
    logic wr_commit;
    logic [1:0] sel_delay;
    logic shift_cfg;
    logic frac_on;
    tcd_seq_if sq ();

    ////////////////////////////////////////////////////////////////////////
    // Register port
    assign wr_commit = reg_wr && reg_addr == `TCD_OFF_COMMIT && reg_wdata[0];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < `TCD_NWORDS; i++)
                shadow_ff[i] <= `TCD_RST_WORD;
        end
        else if (ce && reg_wr && reg_addr[1:0] == 2'h0 && reg_addr < `TCD_OFF_COMMIT)
        begin
            shadow_ff[reg_addr[4:2]] <= reg_wdata;
        end
    end

    // Staged words reach the decode only on commit, so a half-written word set never shows
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            act_ff <= {`TCD_NWORDS{`TCD_RST_WORD}};
            commit_ff <= 1'b0;
        end
        else if (ce)
        begin
            commit_ff <= wr_commit;
            if (wr_commit)
            begin
                for (int i = 0; i < `TCD_NWORDS; i++)
                    act_ff[32*i +: 32] <= shadow_ff[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata_ff <= 32'h00000000;
        end
        else if (ce)
        begin
            reg_rdata_ff <= 32'h00000000;
            if (reg_rd)
            begin
                if (reg_addr[1:0] == 2'h0 && reg_addr < `TCD_OFF_COMMIT)
                    reg_rdata_ff <= shadow_ff[reg_addr[4:2]];
                else if (reg_addr == `TCD_OFF_STATUS)
                    reg_rdata_ff <= {28'h0000000, lk_s2_ff, hc_pump_active_ff, divider_shift_ff, sq.changing};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock indication comes from the analog loop, so it is synchronised first
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lk_s1_ff <= 1'b0;
            lk_s2_ff <= 1'b0;
        end
        else if (ce)
        begin
            lk_s1_ff <= lock_detect_pin;
            lk_s2_ff <= lk_s1_ff;
        end
    end

    assign sel_delay = act_ff[`TCD_B_DEL_SEL] ? act_ff[`TCD_B_DEL2_LO +: 2] : act_ff[`TCD_B_DEL1_LO +: 2];
    assign shift_cfg = !act_ff[`TCD_B_NO_SHIFT];
    assign frac_on = !act_ff[`TCD_B_FRAC_OFF];
    assign sq.start = commit_ff && act_ff[`TCD_B_PLL_ON];
    assign sq.delay_code = sel_delay;
    assign sq.lock = lk_s2_ff;

    tcd_pump_seq u_seq (
        .core_clk (core_clk),
        .rst (rst),
        .ce (ce),
        .sq (sq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Receiver settings
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            if_gain_db_ff <= `TCD_IFG_BASE_DB;
            if_in_am_ff <= 1'b0;
            osc_low_current_ff <= 1'b0;
            rf_gain_threshold_ff <= `TCD_RF_FM_BASE_DB;
        end
        else if (ce)
        begin
            if_gain_db_ff <= `TCD_IFG_BASE_DB + {1'b0, act_ff[`TCD_B_IFG_HI:`TCD_B_IFG_LO], 1'b0};
            if_in_am_ff <= act_ff[`TCD_B_IF_IN_AM];
            osc_low_current_ff <= act_ff[`TCD_B_OSC_LOW];
            rf_gain_threshold_ff <= (act_ff[`TCD_B_AM_MODE] ? `TCD_RF_AM_BASE_DB : `TCD_RF_FM_BASE_DB)
                + {3'h0, act_ff[`TCD_B_RF_HI:`TCD_B_RF_LO]};
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            am_mixer_en_ff <= 1'b0;
            am_rf_gain_threshold_en_ff <= 1'b0;
            am_prescaler_en_ff <= 1'b0;
            am_if_amp_en_ff <= 1'b0;
            fm_mixer_en_ff <= 1'b1;
            fm_rf_gain_threshold_en_ff <= 1'b1;
            fm_if_amp_en_ff <= 1'b1;
            am_phase_detector_path_ff <= 1'b0;
            fm_phase_detector_path_ff <= 1'b1;
            am_prescale_div_ff <= `TCD_PRE_BASE;
            test_mode_ff <= 1'b0;
        end
        else if (ce)
        begin
            am_mixer_en_ff <= act_ff[`TCD_B_AM_MODE];
            am_rf_gain_threshold_en_ff <= act_ff[`TCD_B_AM_MODE];
            am_prescaler_en_ff <= act_ff[`TCD_B_AM_MODE];
            am_if_amp_en_ff <= act_ff[`TCD_B_AM_MODE];
            fm_mixer_en_ff <= !act_ff[`TCD_B_AM_MODE];
            fm_rf_gain_threshold_en_ff <= !act_ff[`TCD_B_AM_MODE];
            fm_if_amp_en_ff <= !act_ff[`TCD_B_AM_MODE];
            // Loop filter path follows its own bit; a mismatch with the mode is the host's to avoid
            am_phase_detector_path_ff <= act_ff[`TCD_B_PD_AM];
            fm_phase_detector_path_ff <= !act_ff[`TCD_B_PD_AM];
            am_prescale_div_ff <= act_ff[`TCD_B_PRE_TEN] ? `TCD_PRE_TEN_DIV
                : `TCD_PRE_BASE + {1'b0, act_ff[`TCD_B_PRE_LO +: 3]};
            test_mode_ff <= act_ff[`TCD_B_TEST];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synthesizer settings
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pll_power_ff <= 1'b0;
            div_input_grounded_ff <= 1'b1;
            main_divider_select_ff <= 1'b0;
            pump_delay_select_ff <= 2'h0;
            divider_shift_ff <= 1'b0;
            frac_mode_ff <= 1'b1;
            n_low_bits_zero_ff <= 1'b0;
            wire_spur_suppress_ff <= 1'b0;
            impulse_spur_suppress_ff <= 1'b0;
        end
        else if (ce)
        begin
            pll_power_ff <= act_ff[`TCD_B_PLL_ON];
            div_input_grounded_ff <= !act_ff[`TCD_B_PLL_ON];
            main_divider_select_ff <= act_ff[`TCD_B_DIV_SEL];
            pump_delay_select_ff <= sel_delay;
            // Reference divider is assumed a multiple of four, so its dropped bits are not checked
            divider_shift_ff <= shift_cfg && sq.changing && act_ff[`TCD_B_PLL_ON];
            frac_mode_ff <= frac_on;
            n_low_bits_zero_ff <= shift_cfg && !frac_on;
            wire_spur_suppress_ff <= frac_on && shift_cfg && act_ff[`TCD_B_WIRE_SUP];
            impulse_spur_suppress_ff <= frac_on && shift_cfg && act_ff[`TCD_B_IMP_SUP];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hc_pump_active_ff <= 1'b0;
            lc_pump_active_ff <= 1'b0;
            hc_pump_2ma_ff <= 1'b0;
            lc_pump_double_ff <= 1'b0;
        end
        else if (ce)
        begin
            hc_pump_active_ff <= sq.hc_active && act_ff[`TCD_B_PLL_ON];
            lc_pump_active_ff <= !sq.hc_active && act_ff[`TCD_B_PLL_ON];
            hc_pump_2ma_ff <= act_ff[`TCD_B_HC_2MA];
            lc_pump_double_ff <= act_ff[`TCD_B_LC_DOUBLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch pins are open drain: the pad only ever pulls low
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            switch_output_one_o_ff <= 1'b0;
            switch_output_one_oe_ff <= 1'b0;
            switch_two_or_gain_pin_o_ff <= 1'b0;
            switch_two_or_gain_pin_oe_ff <= 1'b0;
            gain_pin_agc_mode_ff <= 1'b1;
        end
        else if (ce)
        begin
            switch_output_one_o_ff <= 1'b0;
            switch_output_one_oe_ff <= act_ff[`TCD_B_SW1_LOW];
            switch_two_or_gain_pin_o_ff <= 1'b0;
            // In gain mode the analog stage owns the pin, so the switch stays released
            switch_two_or_gain_pin_oe_ff <= act_ff[`TCD_B_SW2_SWITCH] && act_ff[`TCD_B_SW2_LOW];
            gain_pin_agc_mode_ff <= !act_ff[`TCD_B_SW2_SWITCH];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_if_gain_map: assert property (@(posedge core_clk) disable iff (rst)
        ce |=> (if_gain_db_ff == 6'h0C + {1'b0, $past(act_ff[9:6]), 1'b0}))
        else $error("IF gain does not follow its code");
    a_rf_thresh_map: assert property (@(posedge core_clk) disable iff (rst)
        ce |=> (rf_gain_threshold_ff == ($past(act_ff[17]) ? 7'h58 : 7'h5B) + {3'h0, $past(act_ff[15:12])}))
        else $error("RF threshold wrong for mode");
    a_mode_blocks: assert property (@(posedge core_clk) disable iff (rst)
        ce |=> (am_mixer_en_ff != fm_mixer_en_ff && am_if_amp_en_ff == $past(act_ff[17])))
        else $error("AM and FM blocks not exclusive");
    a_pll_ground: assert property (@(posedge core_clk) disable iff (rst)
        pll_power_ff |-> !div_input_grounded_ff && !(hc_pump_active_ff && lc_pump_active_ff))
        else $error("divider grounded while PLL powered");
    a_commit_apply: assert property (@(posedge core_clk) disable iff (rst)
        (ce && wr_commit) |=> (act_ff[31:0] == $past(shadow_ff[0])))
        else $error("commit did not apply staged word");
    a_hold_value: assert property (@(posedge core_clk) disable iff (rst)
        !wr_commit |=> $stable(act_ff))
        else $error("control bits changed without commit");
    a_sw1_drive: assert property (@(posedge core_clk) disable iff (rst)
        ce |=> (switch_output_one_oe_ff == $past(act_ff[46]) && !switch_output_one_o_ff))
        else $error("switch one drive wrong");
    a_switch_two_or_gain_pin: assert property (@(posedge core_clk) disable iff (rst)
        gain_pin_agc_mode_ff |-> !switch_two_or_gain_pin_oe_ff)
        else $error("switch two driven in gain mode");
    a_presc_range: assert property (@(posedge core_clk) disable iff (rst)
        am_prescale_div_ff >= 4'h2 && am_prescale_div_ff <= 4'hA)
        else $error("prescaler factor out of range");
    a_spur_gate: assert property (@(posedge core_clk) disable iff (rst)
        (wire_spur_suppress_ff || impulse_spur_suppress_ff) |-> frac_mode_ff && !n_low_bits_zero_ff)
        else $error("spur suppression outside fractional shift");
    a_shift_ends: assert property (@(posedge core_clk) disable iff (rst)
        (ce && lk_s2_ff && sq.changing) ##1 ce ##1 ce ##1 ce |-> !divider_shift_ff)
        else $error("divider shift kept after lock");
    c_am_mode: cover property (@(posedge core_clk) disable iff (rst) am_mixer_en_ff && am_prescale_div_ff == 4'hA);
    c_fast_change: cover property (@(posedge core_clk) disable iff (rst) divider_shift_ff && hc_pump_active_ff);
    c_sw2_low: cover property (@(posedge core_clk) disable iff (rst) switch_two_or_gain_pin_oe_ff);
endmodule // tcd_ctrl_top

// ==== rtl/tcd_pkg.sv ====
// Types shared by the tuner control decoder
package tcd_pkg;
    typedef enum logic [2:0] {
        TCD_IDLE = 3'h1,
        TCD_FAST = 3'h2,
        TCD_HOLD = 3'h4
    } tcd_seq_e;
    typedef logic [1:0] tcd_delay_t;
endpackage

// ==== rtl/tcd_pump_seq.sv ====
// Frequency change sequencer: high-current pump phase, lock wait, delayed hand-over
`timescale 1ns/100ps
`include "tcd_consts.svh"
module tcd_pump_seq
    import tcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    tcd_seq_if.seq sq
);
    tcd_seq_e state_ff;
    tcd_delay_t code_ff;
    logic [1:0] cnt_ff;
    logic hc_ff;
    logic chg_ff;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= TCD_IDLE;
            code_ff <= 2'h0;
            cnt_ff <= 2'h0;
        end
        else if (ce)
        begin
            case (state_ff)
                TCD_IDLE:
                begin
                    if (sq.start)
                    begin
                        state_ff <= TCD_FAST;
                        code_ff <= sq.delay_code;
                    end
                end
                TCD_FAST:
                begin
                    // Lock ends the fast phase; code 0 has no pump to hand over
                    if (sq.lock)
                    begin
                        state_ff <= (code_ff == 2'h0) ? TCD_IDLE : TCD_HOLD;
                        cnt_ff <= 2'(`TCD_DELAY_CYC(code_ff));
                    end
                end
                TCD_HOLD:
                begin
                    if (cnt_ff <= 2'h1)
                        state_ff <= TCD_IDLE;
                    else
                        cnt_ff <= cnt_ff - 2'h1;
                end
                default:
                    state_ff <= TCD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hc_ff <= 1'b0;
            chg_ff <= 1'b0;
        end
        else if (ce)
        begin
            hc_ff <= (state_ff == TCD_FAST || state_ff == TCD_HOLD) && code_ff != 2'h0;
            chg_ff <= state_ff == TCD_FAST;
        end
    end

    assign sq.hc_active = hc_ff;
    assign sq.changing = chg_ff;

    ////////////////////////////////////////////////////////////////////////
    a_skip_no_hc: assert property (@(posedge core_clk) disable iff (rst)
        (state_ff != TCD_IDLE && code_ff == 2'h0) ##1 ce |-> !hc_ff)
        else $error("high-current pump active with zero delay code");
    a_hold_bound: assert property (@(posedge core_clk) disable iff (rst)
        (state_ff == TCD_HOLD) |-> ##[0:16] (state_ff == TCD_IDLE))
        else $error("delay hold did not end in time");
    c_hold_seen: cover property (@(posedge core_clk) disable iff (rst) state_ff == TCD_HOLD);
endmodule // tcd_pump_seq

// ==== rtl/tcd_seq_if.sv ====
// Link between the register bank and the charge pump sequencer
`timescale 1ns/100ps
interface tcd_seq_if;
    logic start;
    logic [1:0] delay_code;
    logic lock;
    logic changing;
    logic hc_active;
    modport ctl (output start, output delay_code, output lock, input changing, input hc_active);
    modport seq (input start, input delay_code, input lock, output changing, output hc_active);
endinterface

// ==== tb/tcd_host_model.sv ====
// Host model: loads control words into the bank over the register port
`timescale 1ns/100ps
`include "tcd_consts.svh"
module tcd_host_model
(
    input wire logic core_clk,
    input wire logic [31:0] reg_rdata_ff,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Write data is scrambled once released so a late sample cannot pass by luck
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata_ff;
    endtask

    task automatic load(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w3, input logic [31:0] w4);
        logic [31:0] m3;
        logic [31:0] m4;
        // Test bit and reference divider shift bits always left clear
        m3 = w3 & 32'hC7FFFFFF;
        // Loop filter path follows the reception mode
        m4 = {w4[31:18], w0[`TCD_B_AM_MODE], w4[16:0]};
        wr(`TCD_OFF_WORD0, w0);
        wr(`TCD_OFF_WORD1, w1);
        wr(`TCD_OFF_WORD2, 32'h00000000);
        wr(`TCD_OFF_WORD3, m3);
        wr(`TCD_OFF_WORD4, m4);
        wr(`TCD_OFF_COMMIT, 32'h00000001);
        repeat (3) @(posedge core_clk);
    endtask
endmodule // tcd_host_model

// ==== tb/tuner_control_word_decode_tb.sv ====
// Self-checking bench of the tuner control word bank
`timescale 1ns/100ps
`include "tcd_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tuner_control_word_decode_tb;
    logic core_clk, rst, ce, reg_wr, reg_rd, lock_detect_pin;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_ff;
    logic [5:0] if_gain_db_ff;
    logic [6:0] rf_gain_threshold_ff;
    logic [1:0] pump_delay_select_ff;
    logic [3:0] am_prescale_div_ff;
    logic if_in_am_ff, osc_low_current_ff, am_mixer_en_ff, am_rf_gain_threshold_en_ff, am_prescaler_en_ff, am_if_amp_en_ff;
    logic fm_mixer_en_ff, fm_rf_gain_threshold_en_ff, fm_if_amp_en_ff, am_phase_detector_path_ff, fm_phase_detector_path_ff;
    logic pll_power_ff, div_input_grounded_ff, main_divider_select_ff, divider_shift_ff, frac_mode_ff;
    logic n_low_bits_zero_ff, wire_spur_suppress_ff, impulse_spur_suppress_ff, hc_pump_active_ff, lc_pump_active_ff;
    logic hc_pump_2ma_ff, lc_pump_double_ff, switch_output_one_o_ff, switch_output_one_oe_ff, test_mode_ff;
    logic switch_two_or_gain_pin_o_ff, switch_two_or_gain_pin_oe_ff, gain_pin_agc_mode_ff;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;

    tcd_ctrl_top u_dut (.*);
    tcd_host_model u_host (.core_clk(core_clk), .reg_rdata_ff(reg_rdata_ff), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    always #2.5 core_clk = ~core_clk;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            results;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_reset;
        @(posedge core_clk);
        #1;
        `CHK(if_gain_db_ff, `TCD_IFG_BASE_DB)
        `CHK(rf_gain_threshold_ff, `TCD_RF_FM_BASE_DB)
        `CHK({am_mixer_en_ff, fm_mixer_en_ff, fm_rf_gain_threshold_en_ff, fm_if_amp_en_ff}, 4'h7)
        `CHK({pll_power_ff, div_input_grounded_ff, hc_pump_active_ff}, 3'h2)
        `CHK({frac_mode_ff, gain_pin_agc_mode_ff, am_prescale_div_ff}, {2'h3, `TCD_PRE_BASE})
        $display("test reset done");
    endtask

    task automatic t_decode;
        logic [3:0] k;
        for (int i = 0; i < 16; i++)
        begin
            k = i[3:0];
            u_host.load({14'h0, k[0], 1'b0, ~k, k[2], k[1], k, k[3], 5'h00},
                {k[2], k[1], k[3], k[2], 11'h0, k[3], k[2], k[1], 13'h0, k[0]}, 32'h0, {15'h0, k[1], k, 12'h0});
            #1;
            `CHK(if_gain_db_ff, `TCD_IFG_BASE_DB + {1'b0, k, 1'b0})
            `CHK({if_in_am_ff, osc_low_current_ff}, {k[2], k[1]})
            `CHK(rf_gain_threshold_ff, (k[0] ? `TCD_RF_AM_BASE_DB : `TCD_RF_FM_BASE_DB) + {3'h0, ~k})
            `CHK({am_mixer_en_ff, am_rf_gain_threshold_en_ff, am_prescaler_en_ff, am_if_amp_en_ff}, {4{k[0]}})
            `CHK({fm_mixer_en_ff, fm_rf_gain_threshold_en_ff, fm_if_amp_en_ff}, {3{~k[0]}})
            `CHK({am_phase_detector_path_ff, fm_phase_detector_path_ff}, {k[0], ~k[0]})
            `CHK({pll_power_ff, div_input_grounded_ff, divider_shift_ff}, 3'h2)
            `CHK(main_divider_select_ff, k[3])
            `CHK({frac_mode_ff, n_low_bits_zero_ff}, {~k[1], ~k[0] & k[1]})
            `CHK({wire_spur_suppress_ff, impulse_spur_suppress_ff}, {2{~k[1] & ~k[0]}} & {k[2], k[3]})
            `CHK({switch_output_one_o_ff, switch_output_one_oe_ff}, {1'b0, k[1]})
            `CHK({switch_two_or_gain_pin_o_ff, switch_two_or_gain_pin_oe_ff, gain_pin_agc_mode_ff},
                {1'b0, k[3] & k[2], ~k[3]})
            `CHK({hc_pump_2ma_ff, lc_pump_double_ff, hc_pump_active_ff}, {k[1], k[2], 1'b0})
            `CHK(am_prescale_div_ff, k[3] ? `TCD_PRE_TEN_DIV : `TCD_PRE_BASE + {1'b0, k[2:0]})
            `CHK(test_mode_ff, 1'b0)
        end
        $display("test decode done");
    endtask

    task automatic t_bus;
        logic [31:0] d;
        u_host.wr(`TCD_OFF_WORD0, 32'h00000140);
        u_host.rd(`TCD_OFF_WORD0, d);
        #1;
        `CHK(d, 32'h00000140)
        `CHK(reg_rdata_ff, 32'h00000000)
        `CHK(if_gain_db_ff, 6'h2A)
        u_host.wr(`TCD_OFF_COMMIT, 32'h00000000);
        u_host.wr(8'h20, 32'hFFFFFFFF);
        u_host.rd(8'h1C, d);
        `CHK(d, 32'h00000000)
        u_host.rd(8'h02, d);
        `CHK(d, 32'h00000000)
        u_host.rd(`TCD_OFF_WORD0, d);
        #1;
        `CHK(d, 32'h00000140)
        `CHK(if_gain_db_ff, 6'h2A)
        u_host.wr(`TCD_OFF_COMMIT, 32'h00000001);
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(if_gain_db_ff, 6'h16)
        // A write while the clock enable is low must leave the staged word alone
        ce <= 1'b0;
        u_host.wr(`TCD_OFF_WORD0, 32'h000003C0);
        ce <= 1'b1;
        u_host.rd(`TCD_OFF_WORD0, d);
        `CHK(d, 32'h00000140)
        $display("test bus done");
    endtask

    task automatic t_pump;
        logic [1:0] c;
        logic [31:0] d;
        int n;
        for (int i = 0; i < 8; i++)
        begin
            c = i[1:0];
            u_host.load({8'h00, i[2] ? {c, ~c} : {~c, c}, 1'b0, i[2], 18'h00010}, 32'h0, 32'h0, 32'h0);
            #1;
            `CHK(pump_delay_select_ff, c)
            `CHK({pll_power_ff, div_input_grounded_ff}, 2'h2)
            if (c == 2'h0)
            begin
                repeat (8)
                begin
                    `CHK({hc_pump_active_ff, lc_pump_active_ff}, 2'h1)
                    @(posedge core_clk);
                    #1;
                end
            end
            else
            begin
                `CHK({hc_pump_active_ff, lc_pump_active_ff, divider_shift_ff}, 3'h5)
                u_host.rd(`TCD_OFF_STATUS, d);
                `CHK(d, 32'h00000007)
            end
            @(posedge core_clk);
            lock_detect_pin <= 1'b1;
            #1;
            n = 0;
            // Wait for both the fast pump and the divider shift to end after lock
            while ((hc_pump_active_ff !== 1'b0 || divider_shift_ff !== 1'b0) && n < 30)
            begin
                @(posedge core_clk);
                #1;
                n++;
            end
            `CHK({hc_pump_active_ff, lc_pump_active_ff, divider_shift_ff}, 3'h2)
            // Two sync stages, one sequencer step, the delay cycles, two output stages
            `CHK(n, int'(c) + 5)
            @(posedge core_clk);
            lock_detect_pin <= 1'b0;
            repeat (5) @(posedge core_clk);
        end
        $display("test pump done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        lock_detect_pin = 1'b0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_decode;
        t_bus;
        t_pump;
        results;
    end
endmodule // tuner_control_word_decode_tb
